// ===== testbench/sadu_keypad_model.sv
`default_nettype none
// Operator at the front-panel keypad: every key press is a one-cycle pulse.
module sadu_keypad_model (
  input wire logic clk,
  output logic [7:0] keys
);
  timeunit 1ns;
  timeprecision 1ns;
  initial keys = 8'h00;
  // Launched just after an edge so the unit samples a clean, whole pulse.
  task automatic press(input int k);
    @(posedge clk);
    keys[k] <= 1'b1;
    @(posedge clk);
    keys[k] <= 1'b0;
  endtask
  // Shift first, then clear, with no other key between the two.
  task automatic shift_clear();
    press(6);
    press(7);
  endtask
endmodule
`default_nettype wire

// ===== testbench/sadu_top_monitor.sv
`default_nettype none
module sadu_mon #(
  parameter int IDENT_CYCLES = 20
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [15:0] reg_rdata,
  input wire logic [2:0] powerup_in,
  input wire logic [3:0] holdover_in,
  input wire logic [15:0] hardware_in,
  input wire logic [7:0] cmd_fault_in,
  input wire logic [7:0] operation_in,
  input wire logic time_reset_in,
  input wire logic data_valid,
  input wire logic local_time_sel,
  input wire logic key_time,
  input wire logic key_shift,
  input wire logic key_clear,
  input wire logic [7:0] disp_msg,
  input wire logic alarm_led,
  input wire logic demo_mode
);
  logic [39:0] cond_q;
  logic [5:0] hist;
  int cnt;
  wire logic [39:0] cond = {powerup_in, holdover_in, hardware_in, cmd_fault_in, operation_in,
    time_reset_in};
  wire logic act = (cond != cond_q) || reg_write;
  wire logic quiet = !act && (hist == 6'h00);
  wire logic ok = quiet && (cnt > IDENT_CYCLES + 2) && !demo_mode;
  wire logic [3:0] t_exp = !data_valid ? sadu_pkg::MSG_TIME_PEND :
    (local_time_sel ? sadu_pkg::MSG_TIME_LOCAL : sadu_pkg::MSG_TIME_UTC);
  // An alarm may still be in flight for a few cycles after any input activity.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cond_q <= '0;
      hist <= 6'h3f;
    end
    else
    begin
      cond_q <= cond;
      hist <= {hist[4:0], act};
    end
  end
  // Cycles since reset, saturating past the identification window.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      cnt <= 0;
    else if (cnt < IDENT_CYCLES + 8)
      cnt <= cnt + 1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  top_master_a: assert property (reg_read && reg_addr == sadu_pkg::ADDR_TOP_SUMMARY |=>
    reg_rdata[6] == (reg_rdata[3] || reg_rdata[5] || reg_rdata[7]))
    else $error("Master summary differs from the other summaries");
  alarm_cause_a: assert property (alarm_led |-> disp_msg[7:4] inside {[4'h1:4'h8]})
    else $error("Alarm lit without a source message");
  alarm_held_a: assert property (quiet && alarm_led && key_time |=>
    alarm_led && $stable(disp_msg))
    else $error("Key press displaced the alarm message");
  clear_reply_a: assert property (ok && key_clear && $past(key_shift, 2) |=>
    !alarm_led && disp_msg == {sadu_pkg::GRP_ROUTINE,
    $past(alarm_led) ? sadu_pkg::MSG_CLEARED : sadu_pkg::MSG_NO_ALARM})
    else $error("Wrong reply to alarm clear");
  time_key_a: assert property (ok && !alarm_led && key_time |=>
    disp_msg == {sadu_pkg::GRP_ROUTINE, $past(t_exp)})
    else $error("Wrong time key message");
  routine_dark_a: assert property (quiet && !alarm_led |=> !alarm_led)
    else $error("Alarm lit without a condition change");
  ident_scroll_a: assert property (cnt < IDENT_CYCLES - 2 && !demo_mode |->
    disp_msg == {sadu_pkg::GRP_ROUTINE, sadu_pkg::MSG_IDENT})
    else $error("Identification not shown after reset");
  demo_entry_a: assert property (key_shift && cnt < IDENT_CYCLES - 2 |->
    ##[1:2] demo_mode)
    else $error("Shift during identification did not start demo");
  cover property ($rose(alarm_led));
  cover property (alarm_led && key_clear);
  cover property ($rose(demo_mode));
endmodule
bind sadu_top sadu_mon #(.IDENT_CYCLES(IDENT_CYCLES)) u_mon (.clk(clk), .rst(rst),
  .reg_addr(reg_addr), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .powerup_in(powerup_in), .holdover_in(holdover_in), .hardware_in(hardware_in),
  .cmd_fault_in(cmd_fault_in), .operation_in(operation_in), .time_reset_in(time_reset_in),
  .data_valid(data_valid), .local_time_sel(local_time_sel), .key_time(key_time),
  .key_shift(key_shift), .key_clear(key_clear), .disp_msg(disp_msg), .alarm_led(alarm_led),
  .demo_mode(demo_mode));
`default_nettype wire

// ===== testbench/testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int IDC = 20;
  logic clk, rst, reg_write, reg_read, time_reset_in, data_valid, local_time_sel;
  logic [3:0] reg_addr, holdover_in;
  logic [15:0] reg_wdata, reg_rdata, hardware_in, rd;
  logic [2:0] powerup_in;
  logic [7:0] cmd_fault_in, operation_in, disp_msg;
  logic [1:0] disp_suffix;
  logic alarm_led, demo_mode;
  logic [31:0] seed = 32'h8efb0e8f;
  wire logic [7:0] keys;
  int n_errors, tests_run, cyc, cf, user;
  int vb[7] = '{1, 6, 13, 19, 27, 0, 31};
  logic [7:0] em[7] = '{8'h11, 8'h23, 8'h36, 8'h44, 8'h54, 8'h63, 8'h70};
  sadu_top #(.IDENT_CYCLES(IDC)) u_sadu_top (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .powerup_in(powerup_in), .holdover_in(holdover_in), .hardware_in(hardware_in),
    .cmd_fault_in(cmd_fault_in), .operation_in(operation_in), .time_reset_in(time_reset_in),
    .data_valid(data_valid), .local_time_sel(local_time_sel), .key_time(keys[0]),
    .key_lat(keys[1]), .key_long(keys[2]), .key_alt(keys[3]), .key_sat(keys[4]),
    .key_serial(keys[5]), .key_shift(keys[6]), .key_clear(keys[7]), .disp_msg(disp_msg),
    .disp_suffix(disp_suffix), .alarm_led(alarm_led), .demo_mode(demo_mode));
  sadu_keypad_model u_sadu_keypad_model (.clk(clk), .keys(keys));
  // Free-running system clock.
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // A hang is cut short well after the sequence should have ended.
  always @(posedge clk)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      n_errors++;
      give_verdict();
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Reference model of the readable registers at 0 to 6, built from the documented bits; other addresses model as zero.
  function automatic logic [15:0] exp_reg(input int a);
    logic [7:0] op, top, q;
    logic [15:0] hw;
    hw = hardware_in & 16'h1fdf;
    op = (operation_in & 8'h5a) | {2'h0, |hw, 2'h0, |holdover_in, 1'h0, |powerup_in};
    q = {6'h0, 1'(user), time_reset_in};
    top = {|op, 1'h0, |cf, 1'h0, |q, 3'h0};
    top[6] = |top;
    case (a)
      0: return {13'h0, powerup_in};
      1: return {12'h0, holdover_in};
      2: return hw;
      3: return 16'(cf);
      4: return {8'h0, op};
      5: return {8'h0, q};
      6: return {8'h0, top};
      default: return 16'h0;
    endcase
  endfunction
  task automatic check_reg(input string w, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic check_disp(input string w, input logic l, input logic [7:0] m);
    tests_run++;
    if ({alarm_led, disp_msg} !== {l, m})
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", w, {l, m}, {alarm_led, disp_msg});
    end
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe.
  task automatic reg_rd(input logic [3:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    @(negedge clk);
    rd = reg_rdata;
  endtask
  // Command faults are sticky, so the model keeps every fault ever raised.
  task automatic set_cond(input logic [31:0] v, input logic [7:0] o);
    @(posedge clk);
    powerup_in <= v[2:0];
    holdover_in <= v[6:3];
    hardware_in <= v[22:7];
    cmd_fault_in <= v[30:23] & 8'h3c;
    time_reset_in <= v[31];
    operation_in <= o;
    cf = cf | (v[30:23] & 8'h3c);
  endtask
  // Extra settling lets every alarm in flight land before the next step.
  task automatic wait_alarm();
    for (int i = 0; i < 10 && alarm_led !== 1'b1; i++)
      @(posedge clk);
    repeat (7) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Main sequence.
  initial
  begin
    {rst, reg_write, reg_read, time_reset_in, data_valid, local_time_sel} = 6'h20;
    {reg_addr, holdover_in, powerup_in, cmd_fault_in, operation_in} = 27'h0;
    reg_wdata = 16'h0;
    hardware_in = 16'h0;
    cf = 128;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check_disp("ident", 1'b0, 8'hf0);
    for (int a = 0; a < 16; a = a + (a == 6 ? 9 : 1))
    begin
      reg_rd(a[3:0]);
      check_reg("reset value", exp_reg(a), rd);
    end
    $display("reset test done");
    repeat (IDC) @(posedge clk);
    u_sadu_keypad_model.shift_clear();
    reg_wr(sadu_pkg::ADDR_ALARM_ENABLE, 16'h0000);
    reg_wr(sadu_pkg::ADDR_CMD_FAULT, 16'h00ff);
    cf = 0;
    repeat (8)
    begin
      seed = lfsr(seed);
      set_cond(seed, seed[15:8]);
      user = seed[9];
      reg_wr(sadu_pkg::ADDR_QUESTIONABLE, {14'h0, seed[9], 1'b0});
      for (int a = 0; a < 7; a++)
      begin
        reg_rd(a[3:0]);
        check_reg("register", exp_reg(a), rd);
      end
    end
    reg_wr(sadu_pkg::ADDR_POWERUP, 16'hffff);
    reg_rd(sadu_pkg::ADDR_POWERUP);
    check_reg("read only", exp_reg(0), rd);
    reg_wr(sadu_pkg::ADDR_CMD_FAULT, 16'h00ff);
    cf = cmd_fault_in;
    reg_rd(sadu_pkg::ADDR_CMD_FAULT);
    check_reg("fault clear", exp_reg(3), rd);
    $display("register test done");
    set_cond(0, 0);
    user = 0;
    reg_wr(sadu_pkg::ADDR_QUESTIONABLE, 16'h0);
    reg_wr(sadu_pkg::ADDR_CMD_FAULT, 16'h00ff);
    repeat (8) @(posedge clk);
    reg_wr(sadu_pkg::ADDR_ALARM_ENABLE, 16'h00ff);
    u_sadu_keypad_model.shift_clear();
    @(negedge clk);
    check_disp("masked", 1'b0, 8'hfd);
    for (int k = 0; k < 8; k++)
    begin
      set_cond(k == 7 ? 32'h18 : (k == 5 ? 0 : 32'h1 << vb[k]), k == 5 ? 8'h08 : 8'h00);
      wait_alarm();
      check_disp("onset", 1'b1, k == 7 ? 8'h20 : em[k]);
      check_reg("onset sign", 16'(k == 7 ? sadu_pkg::SFX_QUERY : sadu_pkg::SFX_NONE),
        16'(disp_suffix));
      u_sadu_keypad_model.press(0);
      @(negedge clk);
      check_disp("held", 1'b1, k == 7 ? 8'h20 : em[k]);
      u_sadu_keypad_model.shift_clear();
      @(negedge clk);
      check_disp("cleared", 1'b0, 8'hfc);
      set_cond(0, 0);
      if (k == 4)
        reg_wr(sadu_pkg::ADDR_CMD_FAULT, 16'h0010);
      wait_alarm();
      check_reg("abate sign", 16'(k == 7 ? sadu_pkg::SFX_QUERY : sadu_pkg::SFX_MINUS),
        16'(disp_suffix));
      u_sadu_keypad_model.shift_clear();
    end
    u_sadu_keypad_model.shift_clear();
    @(negedge clk);
    check_disp("no alarm", 1'b0, 8'hfd);
    $display("alarm test done");
    for (int k = 0; k < 11; k++)
    begin
      @(posedge clk);
      data_valid <= k > 3;
      local_time_sel <= k == 5;
      u_sadu_keypad_model.press(k < 4 ? k : (k < 6 ? 0 : k - 5));
      @(negedge clk);
      check_disp("key", 1'b0, 8'hf1 + k[7:0]);
    end
    $display("key test done");
    @(posedge clk);
    rst <= 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    u_sadu_keypad_model.press(6);
    repeat (2) @(posedge clk);
    @(negedge clk);
    check_reg("demo", 16'h1, {15'h0, demo_mode});
    $display("demo test done");
    give_verdict();
  end
endmodule
`default_nettype wire

// ===== verilog/sadu_edge.sv
`default_nettype none
// Watches one condition vector and reports the lowest changed bit with direction.
module sadu_edge #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] cond,
  input wire logic [W-1:0] enable,
  output logic hit,
  output logic [3:0] bit_idx,
  output logic rise,
  output logic both
);
  logic [W-1:0] prev;
  logic [W-1:0] chg;
  logic armed;

  // The first edge after reset only loads the previous value. Without this, a bit that
  // leaves reset already set would be reported as a transition.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      armed <= 1'b0;
    else
      armed <= 1'b1;
  end

  // Previous value for transition detection.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      prev <= '0;
    else
      prev <= cond;
  end

  assign chg = (cond ^ prev) & enable & {W{armed}};

  // Lowest changed bit wins; a second change in the same cycle is reported as ambiguous.
  always_comb
  begin
    hit = 1'b0;
    bit_idx = 4'h0;
    rise = 1'b0;
    both = 1'b0;
    for (int i = W - 1; i >= 0; i--)
    begin
      if (chg[i])
      begin
        both = hit;
        hit = 1'b1;
        bit_idx = 4'(i);
        rise = cond[i];
      end
    end
  end
endmodule
`default_nettype wire

// ===== verilog/sadu_pkg.sv
`default_nettype none
package sadu_pkg;
  // Register offsets on the plain register port.
  localparam logic [3:0] ADDR_POWERUP = 4'h0;
  localparam logic [3:0] ADDR_HOLDOVER = 4'h1;
  localparam logic [3:0] ADDR_HARDWARE = 4'h2;
  localparam logic [3:0] ADDR_CMD_FAULT = 4'h3;
  localparam logic [3:0] ADDR_OPERATION = 4'h4;
  localparam logic [3:0] ADDR_QUESTIONABLE = 4'h5;
  localparam logic [3:0] ADDR_TOP_SUMMARY = 4'h6;
  localparam logic [3:0] ADDR_ALARM_ENABLE = 4'h7;
  localparam logic [3:0] ADDR_DISPLAY = 4'h8;
  localparam logic [3:0] ADDR_CONFIG = 4'h9;
  // Field positions.
  localparam int OPER_PWR_SUM_BIT = 0;
  localparam int OPER_HLD_SUM_BIT = 2;
  localparam int OPER_HW_SUM_BIT = 5;
  localparam int TOP_QUES_SUM_BIT = 3;
  localparam int TOP_CMD_SUM_BIT = 5;
  localparam int TOP_MASTER_SUMMARY_FLAG_BIT = 6;
  localparam int TOP_OPER_SUM_BIT = 7;
  localparam int CMD_PWR_CYCLED_BIT = 7;
  localparam int QUES_USER_BIT = 1;
  // Valid bit masks of each condition register.
  localparam logic [7:0] POWERUP_MASK = 8'h07;
  localparam logic [7:0] HOLDOVER_MASK = 8'h0f;
  localparam logic [15:0] HARDWARE_MASK = 16'h1fdf;
  localparam logic [7:0] CMD_MASK = 8'h3c;
  localparam logic [7:0] OPER_HW_MASK = 8'h5a;
  localparam logic [7:0] QUES_MASK = 8'h03;
  // Reset values.
  localparam logic [7:0] CMD_RESET = 8'h80;
  localparam logic [7:0] ENABLE_RESET = 8'hff;
  // Message source groups carried in the message code high nibble.
  localparam logic [3:0] GRP_NONE = 4'h0;
  localparam logic [3:0] GRP_POWERUP = 4'h1;
  localparam logic [3:0] GRP_HOLDOVER = 4'h2;
  localparam logic [3:0] GRP_HW_LO = 4'h3;
  localparam logic [3:0] GRP_HW_HI = 4'h4;
  localparam logic [3:0] GRP_CMD = 4'h5;
  localparam logic [3:0] GRP_OPER = 4'h6;
  localparam logic [3:0] GRP_QUES = 4'h7;
  localparam logic [3:0] GRP_TOP = 4'h8;
  localparam logic [3:0] GRP_ROUTINE = 4'hf;
  // Routine message codes (low nibble under GRP_ROUTINE).
  localparam logic [3:0] MSG_IDENT = 4'h0;
  localparam logic [3:0] MSG_TIME_PEND = 4'h1;
  localparam logic [3:0] MSG_LAT_PEND = 4'h2;
  localparam logic [3:0] MSG_LONG_PEND = 4'h3;
  localparam logic [3:0] MSG_ALT_PEND = 4'h4;
  localparam logic [3:0] MSG_TIME_UTC = 4'h5;
  localparam logic [3:0] MSG_TIME_LOCAL = 4'h6;
  localparam logic [3:0] MSG_LAT = 4'h7;
  localparam logic [3:0] MSG_LONG = 4'h8;
  localparam logic [3:0] MSG_ALT = 4'h9;
  localparam logic [3:0] MSG_TRACKED = 4'ha;
  localparam logic [3:0] MSG_SERIAL = 4'hb;
  localparam logic [3:0] MSG_CLEARED = 4'hc;
  localparam logic [3:0] MSG_NO_ALARM = 4'hd;
  localparam logic [3:0] MSG_DEMO = 4'he;
  // Transition suffix codes.
  localparam logic [1:0] SFX_NONE = 2'h0;
  localparam logic [1:0] SFX_MINUS = 2'h1;
  localparam logic [1:0] SFX_QUERY = 2'h2;
  // Identification scroll time and its cycle count at 25 MHz.
  localparam int CLK_HZ = 25000000;
  localparam int IDENT_MS = 2000;
  localparam int IDENT_CYCLES = IDENT_MS * (CLK_HZ / 1000);
endpackage
`default_nettype wire

// ===== verilog/sadu_top.sv
`default_nettype none
module sadu_top #(
  parameter int IDENT_CYCLES = sadu_pkg::IDENT_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [15:0] reg_rdata,
  input wire logic [2:0] powerup_in,
  input wire logic [3:0] holdover_in,
  input wire logic [15:0] hardware_in,
  input wire logic [7:0] cmd_fault_in,
  input wire logic [7:0] operation_in,
  input wire logic time_reset_in,
  input wire logic data_valid,
  input wire logic local_time_sel,
  input wire logic key_time,
  input wire logic key_lat,
  input wire logic key_long,
  input wire logic key_alt,
  input wire logic key_sat,
  input wire logic key_serial,
  input wire logic key_shift,
  input wire logic key_clear,
  output logic [7:0] disp_msg,
  output logic [1:0] disp_suffix,
  output logic alarm_led,
  output logic demo_mode
);
  logic [7:0] powerup_condition;
  logic [7:0] holdover_condition;
  logic [15:0] hardware_condition;
  logic [7:0] command_fault_condition;
  logic [7:0] operation_condition;
  logic [7:0] questionable_condition;
  logic [7:0] top_summary_byte;
  logic [7:0] alarm_enable;
  logic [7:0] cmd_latch;
  logic user_event;
  logic [7:0] next_oper;
  logic [7:0] next_top;
  logic shift_armed;
  logic ident_active;
  logic [31:0] ident_cnt;
  logic alarm_latched;
  logic [7:0] alarm_msg;
  logic [1:0] alarm_sfx;
  logic any_key;
  logic [7:0] next_alarm_msg;
  logic [1:0] next_alarm_sfx;
  logic next_alarm_hit;
  logic [3:0] h_idx [0:7];
  logic [7:0] h_hit;
  logic [7:0] h_rise;
  logic [7:0] h_both;
  logic [15:0] mon [0:7];
  logic [15:0] men [0:7];

  // Condition registers built from the live status inputs; command faults and the user bit come from registers.
  always_comb
  begin
    powerup_condition = {5'h00, powerup_in} & sadu_pkg::POWERUP_MASK;
    holdover_condition = {4'h0, holdover_in} & sadu_pkg::HOLDOVER_MASK;
    hardware_condition = hardware_in & sadu_pkg::HARDWARE_MASK;
    command_fault_condition = cmd_latch;
    questionable_condition = {6'h00, user_event, time_reset_in};
  end

  // Summaries are combinational so they move in the same cycle as their sources.
  always_comb
  begin
    next_oper = operation_in & sadu_pkg::OPER_HW_MASK;
    next_oper[sadu_pkg::OPER_PWR_SUM_BIT] = |powerup_condition;
    next_oper[sadu_pkg::OPER_HLD_SUM_BIT] = |holdover_condition;
    next_oper[sadu_pkg::OPER_HW_SUM_BIT] = |hardware_condition;
    next_top = 8'h00;
    next_top[sadu_pkg::TOP_QUES_SUM_BIT] = |questionable_condition;
    next_top[sadu_pkg::TOP_CMD_SUM_BIT] = |command_fault_condition;
    next_top[sadu_pkg::TOP_OPER_SUM_BIT] = |next_oper;
    next_top[sadu_pkg::TOP_MASTER_SUMMARY_FLAG_BIT] = |next_top;
    operation_condition = next_oper;
    top_summary_byte = next_top;
  end

  // Command faults are sticky; power-cycled is set by reset, new faults win over a clear.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      cmd_latch <= sadu_pkg::CMD_RESET;
    else if (reg_write && reg_addr == sadu_pkg::ADDR_CMD_FAULT)
      cmd_latch <= (cmd_latch & ~reg_wdata[7:0]) | (cmd_fault_in & sadu_pkg::CMD_MASK);
    else
      cmd_latch <= cmd_latch | (cmd_fault_in & sadu_pkg::CMD_MASK);
  end

  // The user bit changes only when software writes it and otherwise holds.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      user_event <= 1'b0;
    else if (reg_write && reg_addr == sadu_pkg::ADDR_QUESTIONABLE)
      user_event <= reg_wdata[sadu_pkg::QUES_USER_BIT];
  end

  // Alarm group enable, one bit per source register.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      alarm_enable <= sadu_pkg::ENABLE_RESET;
    else if (reg_write && reg_addr == sadu_pkg::ADDR_ALARM_ENABLE)
      alarm_enable <= reg_wdata[7:0];
  end

  // Register reads answer one cycle later; unmapped addresses read zero.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      reg_rdata <= 16'h0000;
    else if (reg_read)
    begin
      unique case (reg_addr)
        sadu_pkg::ADDR_POWERUP: reg_rdata <= {8'h00, powerup_condition};
        sadu_pkg::ADDR_HOLDOVER: reg_rdata <= {8'h00, holdover_condition};
        sadu_pkg::ADDR_HARDWARE: reg_rdata <= hardware_condition;
        sadu_pkg::ADDR_CMD_FAULT: reg_rdata <= {8'h00, command_fault_condition};
        sadu_pkg::ADDR_OPERATION: reg_rdata <= {8'h00, operation_condition};
        sadu_pkg::ADDR_QUESTIONABLE: reg_rdata <= {8'h00, questionable_condition};
        sadu_pkg::ADDR_TOP_SUMMARY: reg_rdata <= {8'h00, top_summary_byte};
        sadu_pkg::ADDR_ALARM_ENABLE: reg_rdata <= {8'h00, alarm_enable};
        sadu_pkg::ADDR_DISPLAY:
          reg_rdata <= {4'h0, alarm_latched, demo_mode, disp_suffix, disp_msg};
        default: reg_rdata <= 16'h0000;
      endcase
    end
    else
      reg_rdata <= 16'h0000;
  end

  // Monitored vectors, one transition watcher each; hardware is split into two bytes.
  always_comb
  begin
    mon[0] = {8'h00, powerup_condition};
    mon[1] = {8'h00, holdover_condition};
    mon[2] = {8'h00, hardware_condition[7:0]};
    mon[3] = {8'h00, hardware_condition[15:8]};
    mon[4] = {8'h00, command_fault_condition};
    mon[5] = {8'h00, operation_condition};
    mon[6] = {8'h00, questionable_condition};
    mon[7] = {8'h00, top_summary_byte};
    men[0] = {8'h00, {8{alarm_enable[0]}}};
    men[1] = {8'h00, {8{alarm_enable[1]}}};
    men[2] = {8'h00, {8{alarm_enable[2]}}};
    men[3] = {8'h00, {8{alarm_enable[2]}}};
    men[4] = {8'h00, {8{alarm_enable[3]}}};
    men[5] = {8'h00, {8{alarm_enable[4]}}};
    men[6] = {8'h00, {8{alarm_enable[5]}}};
    men[7] = {8'h00, {8{alarm_enable[6]}}};
  end

  // One watcher per alarm group; the top byte is the last group that can raise an alarm.
  for (genvar g = 0; g < 8; g++)
  begin : g_watch
    sadu_edge #(.W(16)) u_edge (
      .clk(clk),
      .rst(rst),
      .cond(mon[g]),
      .enable(men[g]),
      .hit(h_hit[g]),
      .bit_idx(h_idx[g]),
      .rise(h_rise[g]),
      .both(h_both[g])
    );
  end

  // Lowest-numbered group wins; the code names register group and bit.
  always_comb
  begin
    next_alarm_hit = 1'b0;
    next_alarm_msg = 8'h00;
    next_alarm_sfx = sadu_pkg::SFX_NONE;
    for (int i = 7; i >= 0; i--)
    begin
      if (h_hit[i])
      begin
        next_alarm_hit = 1'b1;
        next_alarm_msg = {4'(i + 1), h_idx[i]};
        if (h_both[i])
          next_alarm_sfx = sadu_pkg::SFX_QUERY;
        else if (h_rise[i])
          next_alarm_sfx = sadu_pkg::SFX_NONE;
        else
          next_alarm_sfx = sadu_pkg::SFX_MINUS;
      end
    end
  end

  // Shift arms the clear; it also drives demo entry during the scroll.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      shift_armed <= 1'b0;
    else if (key_shift)
      shift_armed <= 1'b1;
    else if (any_key || key_clear)
      shift_armed <= 1'b0;
  end

  assign any_key = key_time | key_lat | key_long | key_alt | key_sat | key_serial;

  // Identification scroll timer after reset.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ident_active <= 1'b1;
      ident_cnt <= 32'h00000000;
    end
    else if (ident_active)
    begin
      if (ident_cnt == 32'(IDENT_CYCLES - 1))
        ident_active <= 1'b0;
      ident_cnt <= ident_cnt + 32'h00000001;
    end
  end

  // Shift during the scroll enters demonstration mode; shift then clear leaves it.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      demo_mode <= 1'b0;
    else if (ident_active && key_shift)
      demo_mode <= 1'b1;
    else if (shift_armed && key_clear)
      demo_mode <= 1'b0;
  end

  // Latched alarm: a new transition wins over a clear in the same cycle.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      alarm_latched <= 1'b0;
      alarm_msg <= 8'h00;
      alarm_sfx <= sadu_pkg::SFX_NONE;
    end
    else if (next_alarm_hit)
    begin
      alarm_latched <= 1'b1;
      alarm_msg <= next_alarm_msg;
      alarm_sfx <= next_alarm_sfx;
    end
    else if (shift_armed && key_clear)
      alarm_latched <= 1'b0;
  end

  // The indicator follows only the latched alarm, never routine messages. It takes the
  // latch's next value, so it rises and falls in the same cycle as the latch itself.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      alarm_led <= 1'b0;
    else
      alarm_led <= next_alarm_hit || (alarm_latched && !(shift_armed && key_clear));
  end

  // Display selection: a fresh alarm first, so its message appears with the indicator;
  // then the clear reply, a held alarm, the identification scroll, and keypad messages.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      disp_msg <= {sadu_pkg::GRP_ROUTINE, sadu_pkg::MSG_IDENT};
      disp_suffix <= sadu_pkg::SFX_NONE;
    end
    else if (next_alarm_hit)
    begin
      disp_msg <= next_alarm_msg;
      disp_suffix <= next_alarm_sfx;
    end
    else if (shift_armed && key_clear)
    begin
      disp_suffix <= sadu_pkg::SFX_NONE;
      if (alarm_latched)
        disp_msg <= {sadu_pkg::GRP_ROUTINE, sadu_pkg::MSG_CLEARED};
      else
        disp_msg <= {sadu_pkg::GRP_ROUTINE, sadu_pkg::MSG_NO_ALARM};
    end
    else if (alarm_latched)
    begin
      disp_msg <= alarm_msg;
      disp_suffix <= alarm_sfx;
    end
    else if (ident_active)
      disp_msg <= demo_mode ? {sadu_pkg::GRP_ROUTINE, sadu_pkg::MSG_DEMO}
                            : {sadu_pkg::GRP_ROUTINE, sadu_pkg::MSG_IDENT};
    else if (any_key)
    begin
      disp_suffix <= sadu_pkg::SFX_NONE;
      if (key_time)
      begin
        if (!data_valid && !demo_mode)
          disp_msg <= {sadu_pkg::GRP_ROUTINE, sadu_pkg::MSG_TIME_PEND};
        else if (local_time_sel)
          disp_msg <= {sadu_pkg::GRP_ROUTINE, sadu_pkg::MSG_TIME_LOCAL};
        else
          disp_msg <= {sadu_pkg::GRP_ROUTINE, sadu_pkg::MSG_TIME_UTC};
      end
      else if (key_lat)
        disp_msg <= {sadu_pkg::GRP_ROUTINE, (data_valid || demo_mode) ?
                     sadu_pkg::MSG_LAT : sadu_pkg::MSG_LAT_PEND};
      else if (key_long)
        disp_msg <= {sadu_pkg::GRP_ROUTINE, (data_valid || demo_mode) ?
                     sadu_pkg::MSG_LONG : sadu_pkg::MSG_LONG_PEND};
      else if (key_alt)
        disp_msg <= {sadu_pkg::GRP_ROUTINE, (data_valid || demo_mode) ?
                     sadu_pkg::MSG_ALT : sadu_pkg::MSG_ALT_PEND};
      else if (key_sat)
        disp_msg <= {sadu_pkg::GRP_ROUTINE, sadu_pkg::MSG_TRACKED};
      else
        disp_msg <= {sadu_pkg::GRP_ROUTINE, sadu_pkg::MSG_SERIAL};
    end
  end
endmodule
`default_nettype wire
